// ===== verilog/rtcp_pkg.sv
// shared types and constants for the multiplexed host port
package rtcp_pkg;

  // ---------------------------------------------------------------
  // widths and values after reset
  // ---------------------------------------------------------------
  localparam int RTCP_BUS_W = 8;
  localparam logic RTCP_RST_PWR_N = 1'b1;
  localparam logic RTCP_RST_STROBE_N = 1'b1;
  localparam logic RTCP_RST_ALE = 1'b0;
  localparam logic [RTCP_BUS_W-1:0] RTCP_RST_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // bus phase, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RTCP_IDLE  = 3'b001,
    RTCP_READ  = 3'b010,
    RTCP_WRITE = 3'b100
  } rtcp_phase_t;

  // ---------------------------------------------------------------
  // host strobes sampled together
  // ---------------------------------------------------------------
  typedef struct packed {
    logic chip_select_n;
    logic addr_strobe;
    logic read_strobe_n;
    logic write_strobe_n;
  } rtcp_strobe_t;

  // ---------------------------------------------------------------
  // supply and power-control inputs
  // ---------------------------------------------------------------
  typedef struct packed {
    logic main_supply_ok;
    logic aux_battery_enable;
    logic aux_battery_supply;
    logic power_sw_on;
  } rtcp_power_t;

  // ---------------------------------------------------------------
  // complete module state
  // ---------------------------------------------------------------
  typedef struct packed {
    rtcp_phase_t phase;
    rtcp_strobe_t strobe_prev;
    logic kickstart_prev;
    logic [RTCP_BUS_W-1:0] addr;
    logic [RTCP_BUS_W-1:0] wdata;
    logic reg_wr_pulse;
    logic [RTCP_BUS_W-1:0] bus_out;
    logic bus_oe;
    logic irq_oe;
    logic power_on_request_n;
    logic kickstart_irq;
  } rtcp_state_t;

endpackage

// ===== verilog/rtcp_port.sv
// multiplexed host bus port with power-on and interrupt request pins
// Function
// R1 - no main supply: power on by kickstart/wake
// R2 - main supply: power level follows software bit
// R3 - no main supply: kickstart fall requests power
// R4 - software sets aux enable, aux supply present
// R5 - main supply: kickstart becomes interrupt source
// R6 - host asserts chip select for register access
// R7 - host holds chip select through strobes
// R8 - address latched without select, no data
// R9 - address captured on address strobe fall
// R10 - write strobe with select writes register
// R11 - drive bus only during read with select
// R12 - interrupt low while enabled flag set
// R13 - software clears enabled flags to release
// R14 - interrupt pin undriven when nothing pending
// R15 - interrupt pin open drain, pulls low only
// R16 - address first, data second, same lines
// R17 - drive eight data bits during read
// R18 - release bus when read strobe rises
// R19 - host keeps write data stable late
// R20 - address held until next strobe fall
`timescale 1ns/1ps

module rtcp_port #(
  parameter int FLAG_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic chip_select_n,
  input wire logic addr_strobe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [rtcp_pkg::RTCP_BUS_W-1:0] muxed_addr_data_bus_in,
  output logic [rtcp_pkg::RTCP_BUS_W-1:0] muxed_addr_data_bus_out,
  output logic muxed_addr_data_bus_oe,
  input wire logic irq_request_in,
  output logic irq_request_out,
  output logic irq_request_oe,
  input wire logic [FLAG_W-1:0] irq_flags,
  input wire logic [FLAG_W-1:0] irq_enables,
  input wire logic kickstart_n,
  input wire logic wake_alarm,
  input wire logic main_supply_ok,
  input wire logic aux_battery_enable,
  input wire logic aux_battery_supply,
  input wire logic power_sw_on,
  output logic power_on_request_n,
  output logic kickstart_irq,
  output logic [rtcp_pkg::RTCP_BUS_W-1:0] reg_addr,
  output logic [rtcp_pkg::RTCP_BUS_W-1:0] reg_wdata,
  output logic reg_wr_pulse,
  input wire logic [rtcp_pkg::RTCP_BUS_W-1:0] reg_rdata
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic fell(input logic prev, input logic now);
    fell = prev & ~now;
  endfunction

  function automatic logic rose(input logic prev, input logic now);
    rose = ~prev & now;
  endfunction

  // ---------------------------------------------------------------
  // input grouping
  // ---------------------------------------------------------------
  rtcp_pkg::rtcp_strobe_t strobe;
  rtcp_pkg::rtcp_power_t power;
  rtcp_pkg::rtcp_state_t st;
  rtcp_pkg::rtcp_state_t next_st;
  logic sel;
  logic aux_ok;
  logic ks_fall;
  logic irq_pending;

  always_comb
  begin
    strobe.chip_select_n = chip_select_n;
    strobe.addr_strobe = addr_strobe;
    strobe.read_strobe_n = read_strobe_n;
    strobe.write_strobe_n = write_strobe_n;
    power.main_supply_ok = main_supply_ok;
    power.aux_battery_enable = aux_battery_enable;
    power.aux_battery_supply = aux_battery_supply;
    power.power_sw_on = power_sw_on;
  end

  // without select no data moves at all
  assign sel = ~strobe.chip_select_n; // R6
  // backup path usable only with enable bit and supply present
  assign aux_ok = power.aux_battery_enable & power.aux_battery_supply; // R4
  assign ks_fall = fell(st.kickstart_prev, kickstart_n);
  assign irq_pending = |(irq_flags & irq_enables); // R12

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.strobe_prev = strobe;
    next_st.kickstart_prev = kickstart_n;
    next_st.reg_wr_pulse = 1'b0;
    next_st.kickstart_irq = 1'b0;

    // address latched on strobe fall, select not needed
    if (fell(st.strobe_prev.addr_strobe, strobe.addr_strobe)) // R9 R8 R16
    begin
      next_st.addr = muxed_addr_data_bus_in;
    end
    // otherwise the latched address stands for all strobes R20

    case (st.phase)
      rtcp_pkg::RTCP_IDLE:
      begin
        if (sel && !strobe.read_strobe_n) // R11
        begin
          next_st.phase = rtcp_pkg::RTCP_READ;
        end
        else if (sel && !strobe.write_strobe_n) // R10
        begin
          next_st.phase = rtcp_pkg::RTCP_WRITE;
          next_st.wdata = muxed_addr_data_bus_in;
        end
      end
      rtcp_pkg::RTCP_READ:
      begin
        // select dropped mid-strobe also ends the drive
        if (strobe.read_strobe_n || !sel) // R18 R7
        begin
          next_st.phase = rtcp_pkg::RTCP_IDLE;
        end
      end
      rtcp_pkg::RTCP_WRITE:
      begin
        if (!strobe.write_strobe_n && sel)
        begin
          // keep the latest byte, the late part of the pulse wins
          next_st.wdata = muxed_addr_data_bus_in; // R19
        end
        else
        begin
          next_st.phase = rtcp_pkg::RTCP_IDLE;
          next_st.reg_wr_pulse = 1'b1; // R10
        end
      end
      default:
      begin
        next_st.phase = rtcp_pkg::RTCP_IDLE;
      end
    endcase

    // drivers on only while read and select both low
    next_st.bus_oe = (next_st.phase == rtcp_pkg::RTCP_READ); // R11 R18
    if (next_st.phase == rtcp_pkg::RTCP_READ)
    begin
      next_st.bus_out = reg_rdata; // R17
    end

    // open-drain request, only ever pulls low
    next_st.irq_oe = irq_pending; // R12 R14 R15

    // power-on request
    if (power.main_supply_ok)
    begin
      next_st.power_on_request_n = ~power.power_sw_on; // R2
      next_st.kickstart_irq = ks_fall; // R5
    end
    else if (aux_ok && (ks_fall || wake_alarm)) // R1 R3
    begin
      next_st.power_on_request_n = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.phase <= rtcp_pkg::RTCP_IDLE;
      st.strobe_prev.chip_select_n <= rtcp_pkg::RTCP_RST_STROBE_N;
      st.strobe_prev.addr_strobe <= rtcp_pkg::RTCP_RST_ALE;
      st.strobe_prev.read_strobe_n <= rtcp_pkg::RTCP_RST_STROBE_N;
      st.strobe_prev.write_strobe_n <= rtcp_pkg::RTCP_RST_STROBE_N;
      st.kickstart_prev <= rtcp_pkg::RTCP_RST_STROBE_N;
      st.addr <= rtcp_pkg::RTCP_RST_BYTE;
      st.wdata <= rtcp_pkg::RTCP_RST_BYTE;
      st.reg_wr_pulse <= 1'b0;
      st.bus_out <= rtcp_pkg::RTCP_RST_BYTE;
      st.bus_oe <= 1'b0;
      st.irq_oe <= 1'b0;
      st.power_on_request_n <= rtcp_pkg::RTCP_RST_PWR_N;
      st.kickstart_irq <= 1'b0;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flip-flops except irq_request_out, tied low
  // ---------------------------------------------------------------
  assign muxed_addr_data_bus_out = st.bus_out;
  assign muxed_addr_data_bus_oe = st.bus_oe;
  assign irq_request_out = 1'b0; // R15
  assign irq_request_oe = st.irq_oe;
  assign power_on_request_n = st.power_on_request_n;
  assign kickstart_irq = st.kickstart_irq;
  assign reg_addr = st.addr;
  assign reg_wdata = st.wdata;
  assign reg_wr_pulse = st.reg_wr_pulse;

endmodule

// ===== test/rtcp_port_monitor.sv
// assertion checker for the multiplexed host port
`timescale 1ns/1ps
module rtcp_port_monitor #(
  parameter int FLAG_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic chip_select_n,
  input wire logic addr_strobe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] muxed_addr_data_bus_in,
  input wire logic [7:0] muxed_addr_data_bus_out,
  input wire logic muxed_addr_data_bus_oe,
  input wire logic irq_request_out,
  input wire logic irq_request_oe,
  input wire logic [FLAG_W-1:0] irq_flags,
  input wire logic [FLAG_W-1:0] irq_enables,
  input wire logic kickstart_n,
  input wire logic wake_alarm,
  input wire logic main_supply_ok,
  input wire logic aux_battery_enable,
  input wire logic aux_battery_supply,
  input wire logic power_sw_on,
  input wire logic power_on_request_n,
  input wire logic kickstart_irq,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_pulse,
  input wire logic [7:0] reg_rdata
);
  wire aux_ok = aux_battery_enable && aux_battery_supply;
  wire oe = muxed_addr_data_bus_oe;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n || !clk_en);
  AST_IRQ_LEVEL: assert property ($past(rst_n) |-> irq_request_oe ==
    $past(|(irq_flags & irq_enables))) else $error("irq level wrong");
  AST_IRQ_LOW: assert property (irq_request_out == 1'h0)
    else $error("irq pin drives high");
  AST_OE_CAUSE: assert property ($rose(oe) |-> $past(!chip_select_n && !read_strobe_n))
    else $error("bus driven without read");
  AST_OE_OFF: assert property (oe && read_strobe_n |=> !oe)
    else $error("bus not released");
  AST_RDATA: assert property (oe |-> muxed_addr_data_bus_out == $past(reg_rdata))
    else $error("read data wrong");
  AST_ADDR: assert property ($fell(addr_strobe) |=> reg_addr == $past(muxed_addr_data_bus_in))
    else $error("address not taken");
  AST_ADDR_HOLD: assert property (!$fell(addr_strobe) |=> $stable(reg_addr))
    else $error("address changed");
  AST_WRITE: assert property (reg_wr_pulse |-> $past(!chip_select_n && !write_strobe_n, 2)
    && reg_wdata == $past(muxed_addr_data_bus_in, 2) ##1 !reg_wr_pulse) else $error("bad write");
  AST_KICK_IRQ: assert property ($fell(kickstart_n) && main_supply_ok |=> kickstart_irq)
    else $error("no kickstart irq");
  AST_WAKE: assert property (($fell(kickstart_n) || wake_alarm) && !main_supply_ok
    && aux_ok |=> !power_on_request_n) else $error("no power request");
  AST_SW_PWR: assert property (main_supply_ok |=> power_on_request_n == !$past(power_sw_on))
    else $error("power level wrong");
  cover property ($rose(oe));
  cover property (reg_wr_pulse);
  cover property ($fell(power_on_request_n) && !main_supply_ok);
endmodule
bind rtcp_port rtcp_port_monitor #(.FLAG_W(FLAG_W)) i_rtcp_port_monitor (.*);

// ===== test/rtcp_host_model.sv
// host processor model for the multiplexed bus
`timescale 1ns/1ps
module rtcp_host_model (
  input wire logic core_clk,
  input wire logic [7:0] bus_in,
  output logic cs_n,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] bus
);
  initial
  begin
    {cs_n, ale, rd_n, wr_n, bus} = 12'hB00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic addr(input logic [7:0] a);
    ale = 1'h1;
    bus = a;
    step(1);
    ale = 1'h0;
    step(1);
    bus = ~a;
    step(1);
  endtask
  task automatic write(input logic [7:0] d, input logic sel_n);
    cs_n = sel_n;
    wr_n = 1'h0;
    bus = d;
    step(2);
    {cs_n, wr_n} = 2'h3;
    step(1);
    bus = ~d;
    step(1);
  endtask
  task automatic read(output logic [7:0] d, input logic sel_n);
    cs_n = sel_n;
    rd_n = 1'h0;
    step(3);
    d = bus_in;
    {cs_n, rd_n} = 2'h3;
    step(2);
  endtask
endmodule

// ===== test/tb.sv
// testbench for the multiplexed host port
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'h0, rst_n = 1'h0, ks_n = 1'h1, wake = 1'h0, sw = 1'h0;
  logic main_ok = 1'h1, aux_en = 1'h1, clk_en = 1'h1, aux_sup = 1'h1;
  logic [7:0] flags = 8'h00, en = 8'h00, bus_out, bus_in, h_bus, reg_addr, wdata, d, a;
  logic oe, irq_out, irq_oe, pwr_n, ks_irq, wr_pulse, cs_n, ale, rd_n, wr_n;
  int miscompares = 0, comparisons = 0, n_wr = 0, n_ks = 0;
  wire irq_line = irq_oe ? irq_out : 1'h1;
  assign bus_in = oe ? bus_out : h_bus;
  rtcp_port i_rtcp_port (.core_clk, .rst_n, .clk_en, .chip_select_n(cs_n),
    .addr_strobe(ale), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .muxed_addr_data_bus_in(bus_in), .muxed_addr_data_bus_out(bus_out),
    .muxed_addr_data_bus_oe(oe), .irq_request_in(irq_line), .irq_request_out(irq_out),
    .irq_request_oe(irq_oe), .irq_flags(flags), .irq_enables(en), .kickstart_n(ks_n),
    .wake_alarm(wake), .main_supply_ok(main_ok), .aux_battery_enable(aux_en),
    .aux_battery_supply(aux_sup), .power_sw_on(sw), .power_on_request_n(pwr_n),
    .kickstart_irq(ks_irq), .reg_addr, .reg_wdata(wdata), .reg_wr_pulse(wr_pulse),
    .reg_rdata(reg_addr ^ 8'h5A));
  rtcp_host_model h (.core_clk, .bus_in, .cs_n, .ale, .rd_n, .wr_n, .bus(h_bus));
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    n_wr += wr_pulse;
    n_ks += ks_irq;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #100us;
    miscompares++;
    give_verdict();
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    #2 rst_n = 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      a = 8'hFF - 8'(i * 8'h55);
      h.addr(a);
      h.write(~a, i[0]);
      check(reg_addr, a);
      check(8'(n_wr), 8'(i / 2 + 1));
      check(wdata, i[0] ? ~(a + 8'h55) : ~a);
      h.read(d, i[0]);
      check(d, i[0] ? a : a ^ 8'h5A);
      h.read(d, 1'h0);
      check(d, a ^ 8'h5A);
      check(8'(oe), 8'h00);
    end
    flags = 8'h81;
    en = 8'h80;
    h.step(2);
    check(8'(irq_line), 8'h00);
    en = 8'h02;
    h.step(2);
    check(8'(irq_line), 8'h01);
    {flags, en} = 16'h0081;
    h.step(2);
    check(8'(irq_line), 8'h01);
    sw = 1'h1;
    h.step(2);
    check(8'(pwr_n), 8'h00);
    clk_en = 1'h0;
    sw = 1'h0;
    h.step(3);
    check(8'(pwr_n), 8'h00);
    clk_en = 1'h1;
    h.step(2);
    check(8'(pwr_n), 8'h01);
    ks_n = 1'h0;
    h.step(2);
    check(8'(n_ks), 8'h01);
    {ks_n, sw, main_ok, aux_en} = 4'h8;
    h.step(1);
    ks_n = 1'h0;
    h.step(2);
    check(8'(pwr_n), 8'h01);
    {ks_n, aux_en, aux_sup} = 3'h6;
    h.step(1);
    ks_n = 1'h0;
    h.step(2);
    check(8'(pwr_n), 8'h01);
    aux_sup = 1'h1;
    {ks_n, aux_en} = 2'h3;
    h.step(1);
    ks_n = 1'h0;
    h.step(2);
    check(8'(pwr_n), 8'h00);
    {ks_n, main_ok} = 2'h3;
    h.step(2);
    check(8'(pwr_n), 8'h01);
    {main_ok, wake} = 2'h1;
    h.step(2);
    check(8'(pwr_n), 8'h00);
    check(8'(n_ks), 8'h01);
    give_verdict();
  end
endmodule
